// File: pkg/dtc_map.svh
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// register byte offsets
`define DTC_OFS_CTRL 4'h0
`define DTC_OFS_STAT 4'h4

// memory_timing_control reset value and writable bits
`define DTC_CTRL_RST 32'h0000_0000
`define DTC_CTRL_WMASK 32'hf8bb_ffff

// memory_timing_control field positions
`define DTC_POS_ROW_HOLD 31
`define DTC_POS_REFRESH_WAIT 27
`define DTC_POS_CAS_NEG 23
`define DTC_POS_ROW_PRE 19
`define DTC_POS_ROW_COL 16
`define DTC_POS_WR_PRE 13
`define DTC_POS_REF_ASSERT 10
`define DTC_POS_BURST 9
`define DTC_POS_WIDTH 7
`define DTC_POS_MUX_EXT 6
`define DTC_POS_COL_MUX 3
`define DTC_POS_EXT_OUT 0

// status register field positions
`define DTC_POS_ST_ACT_OK 0
`define DTC_POS_ST_PRE_OK 1
`define DTC_POS_ST_RAS_HOLD 2
`define DTC_POS_ST_CFG_ERR 3
`define DTC_POS_ST_ACT_CNT 8
`define DTC_POS_ST_PRE_CNT 16
`define DTC_POS_ST_RAS_CNT 24

// timing counts in clock cycles, plus the base column bit count
`define DTC_REFRESH_WAIT_STEP 6'h03
`define DTC_REF_ASSERT_BASE 4'h2
`define DTC_SD_REFRESH_BASE 6'h04
`define DTC_ROW_COL_BASE 3'h2
`define DTC_COL_BITS_BASE 4'h8

`endif

// File: pkg/dtc_pkg.sv
package dtc_pkg;

  // bus handshake state, value is the waitrequest level
  typedef enum logic {
    BUS_ACK = 1'b0,
    BUS_WAIT = 1'b1
  } dtc_bus_e;

  typedef enum logic [1:0] {
    W64 = 2'b00,
    W_BAD = 2'b01,
    W16 = 2'b10,
    W32 = 2'b11
  } dtc_width_e;

  typedef enum logic [2:0] {
    S8 = 3'b000,
    S16 = 3'b001,
    S32 = 3'b010,
    S64 = 3'b011,
    S32B = 3'b100
  } dtc_size_e;

  typedef enum logic [1:0] {
    XF_SINGLE = 2'b00,
    XF_PAGE = 2'b01,
    XF_EDO = 2'b10,
    XF_SD_BURST = 2'b11
  } dtc_xfer_e;

  // sequencer events, one-cycle pulses
  typedef struct packed {
    logic precharge;
    logic refresh;
    logic write_end;
  } dtc_event_s;

  // decoded configuration for the sequencer
  typedef struct packed {
    logic [1:0] cas_cyc;
    logic [2:0] rc_cyc;
    dtc_width_e width;
    logic [3:0] col_bits;
    logic [4:0] row_shift;
    dtc_xfer_e xfer;
    logic burst;
    logic cfg_err;
  } dtc_cfg_s;

  typedef struct packed {
    dtc_bus_e bus;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [5:0] act_cnt;
    logic [2:0] pre_cnt;
    logic [3:0] ras_cnt;
    logic act_ok;
    logic pre_ok;
    logic ras_hold;
    dtc_cfg_s cfg;
  } dtc_state_s;

endpackage

// File: testbench/dtc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory side: reports each issued command as a one-cycle event
module dtc_mem_model (
  // command chosen by the bench
  input wire dtc_pkg::dtc_event_s cmd,
  // event pulses to the controller
  output dtc_pkg::dtc_event_s events
);
  // no register here, so the event edge is the command edge
  assign events = cmd;
endmodule
`default_nettype wire

// File: testbench/dtc_timing_props.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_timing_props (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // sequencer side
  input wire logic SDRAM_SEL,
  input wire dtc_pkg::dtc_event_s EVENTS,
  // permits and config
  input wire logic ACT_ALLOW,
  input wire logic RAS_HOLD,
  input wire dtc_pkg::dtc_cfg_s CFG
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // bus answers last one cycle and only follow a request
  chk_wait_pulse: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  chk_ack_cause: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ) || $past(AVS_WRITE))
    else $error("acknowledge without a request");
  chk_rsvd_zero: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS[3:2] == 2'h0
    |-> AVS_READDATA[26:24] == 3'h0 && !AVS_READDATA[22] && !AVS_READDATA[18])
    else $error("reserved control bits read as one");
  // sdram decode ignores cas bit and burst bit
  chk_sd_cas: assert property ($past(SDRAM_SEL) |-> CFG.cas_cyc == 2'h1)
    else $error("cas period applied in sdram mode");
  chk_sd_burst: assert property ($past(SDRAM_SEL) |-> CFG.burst && CFG.xfer == dtc_pkg::XF_SD_BURST)
    else $error("sdram access not a burst");
  // lockouts start at the event edge
  chk_sd_pre_lock: assert property (SDRAM_SEL && EVENTS.precharge |=> !ACT_ALLOW)
    else $error("activation allowed right after precharge");
  chk_ref_hold: assert property (!SDRAM_SEL && EVENTS.refresh |=> RAS_HOLD [*2])
    else $error("refresh ras hold shorter than two cycles");
  chk_hold_block: assert property (RAS_HOLD |-> !ACT_ALLOW)
    else $error("activation allowed during refresh hold");
  chk_sd_ref_lock: assert property (SDRAM_SEL && EVENTS.refresh |=> !ACT_ALLOW [*4])
    else $error("activation allowed within four cycles of refresh");

  // main scenarios
  cov_sd_ref: cover property (SDRAM_SEL && EVENTS.refresh);
  cov_dram_ref: cover property (!SDRAM_SEL && EVENTS.refresh);
  cov_write_ack: cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule

bind dtc_timing_config dtc_timing_props i_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SDRAM_SEL(SDRAM_SEL),
  .EVENTS(EVENTS), .ACT_ALLOW(ACT_ALLOW), .RAS_HOLD(RAS_HOLD), .CFG(CFG));
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [31:0] ctl;
    logic sd;
    logic [2:0] ev;
    logic [7:0] na, np, nr;
  } dtc_row_s;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, sd = 1'b0, area = 1'b1;
  logic [3:0] adr = 4'h0, be = 4'hf;
  logic [31:0] wd = 32'h0, rdat, q;
  logic act, pre, ras, wreq;
  dtc_pkg::dtc_width_e aw = dtc_pkg::W16;
  dtc_pkg::dtc_size_e sz = dtc_pkg::S8;
  dtc_pkg::dtc_event_s cmd = '0, ev;
  dtc_pkg::dtc_cfg_s cfg;
  int miscompares = 0, n_checks = 0;
  // control word, sdram, event, then act/pre/ras low-or-high cycle counts; ff in the act count means not judged
  dtc_row_s rows [12] = '{
    '{32'h0010_0000, 1'b1, 3'b100, 8'd3, 8'd0, 8'd0},
    '{32'h0038_0000, 1'b1, 3'b100, 8'd8, 8'd0, 8'd0},
    '{32'h0038_0000, 1'b0, 3'b100, 8'd7, 8'd0, 8'd0},
    '{32'h0000_0000, 1'b0, 3'b100, 8'd0, 8'd0, 8'd0},
    '{32'h0008_8000, 1'b1, 3'b001, 8'd7, 8'd0, 8'd0},
    '{32'h8008_2000, 1'b1, 3'b001, 8'd0, 8'd2, 8'd0},
    '{32'h3800_1c00, 1'b1, 3'b010, 8'd32, 8'd0, 8'd0},
    '{32'h0800_0000, 1'b1, 3'b010, 8'd7, 8'd0, 8'd0},
    '{32'h0000_1c00, 1'b0, 3'b010, 8'hff, 8'd0, 8'd9},
    '{32'h0000_0000, 1'b0, 3'b010, 8'hff, 8'd0, 8'd2},
    '{32'h0000_2000, 1'b0, 3'b001, 8'd0, 8'd0, 8'd0},
    '{32'h0038_0000, 1'b1, 3'b110, 8'd8, 8'd0, 8'd0}};
  // transfer selection cases
  logic [31:0] fp_ctl [5] = '{32'h380, 32'h380, 32'h380, 32'h300, 32'h180};
  dtc_pkg::dtc_size_e fp_sz [5] = '{dtc_pkg::S64, dtc_pkg::S16, dtc_pkg::S32B, dtc_pkg::S32, dtc_pkg::S64};
  logic [1:0] fp_xf [5] = '{2'b01, 2'b00, 2'b01, 2'b01, 2'b00};

  dtc_mem_model i_mem (.cmd(cmd), .events(ev));
  dtc_timing_config i_dut (.REF_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .SDRAM_SEL(sd), .MEM_AREA(area), .AREA_WIDTH(aw), .XFER_SIZE(sz),
    .EVENTS(ev), .ACT_ALLOW(act), .PRE_ALLOW(pre), .RAS_HOLD(ras), .CFG(cfg));

  // 40 mhz clock
  always #12.5 clk = ~clk;

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cyc(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %0d cycles, want %0d", $time, got, exp);
    end
  endtask

  // one access, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20) begin
      miscompares++;
      test_done();
    end
  endtask

  // program, pulse the row's events for one cycle, count lockout cycles over a fixed window
  task automatic run(input dtc_row_s r);
    logic [7:0] na = 8'h0, np = 8'h0, nr = 8'h0;
    sd <= r.sd;
    bus(1'b1, 4'h0, r.ctl, 4'hf);
    @(posedge clk);
    cmd <= r.ev;
    @(posedge clk);
    cmd <= '0;
    repeat (40) begin
      @(negedge clk);
      na = na + {7'h0, act === 1'b0};
      np = np + {7'h0, pre === 1'b0};
      nr = nr + {7'h0, ras === 1'b1};
    end
    @(posedge clk);
    if (r.na !== 8'hff) cmp_cyc(na, r.na);
    cmp_cyc(np, r.np);
    cmp_cyc(nr, r.nr);
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    // reserved bits and byte lanes
    bus(1'b1, 4'h0, 32'hffff_ffff, 4'hf);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    cmp_word(q, 32'hf8bb_ffff);
    bus(1'b1, 4'h0, 32'h0, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    cmp_word(q, 32'hf8bb_ff00);
    // unmapped place keeps nothing
    bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    cmp_word(q, 32'h0);
    // second power-on reset clears the word
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    cmp_word(q, 32'h0);
    // dram edo, 12 column bits, 32-bit width over a 16-bit area, extension kept zero
    sd <= 1'b0;
    bus(1'b1, 4'h0, 32'h0003_03a1, 4'hf);
    @(posedge clk);
    @(negedge clk);
    cmp_word({12'h0, cfg.cas_cyc, cfg.burst, cfg.cfg_err, cfg.rc_cyc, cfg.width, cfg.col_bits, cfg.row_shift,
      cfg.xfer}, {12'h0, 2'h1, 1'b1, 1'b0, 3'h5, 2'b11, 4'hc, 5'd14, 2'b10});
    @(posedge clk);
    sd <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmp_word({12'h0, cfg.cas_cyc, cfg.burst, cfg.cfg_err, cfg.rc_cyc, cfg.width, cfg.col_bits, cfg.row_shift,
      cfg.xfer}, {12'h0, 2'h1, 1'b1, 1'b0, 3'h4, 2'b11, 4'hc, 5'd15, 2'b11});
    @(posedge clk);
    sd <= 1'b0;
    // fast page only for wide transfers over a narrow bus
    for (int k = 0; k < 5; k++) begin
      sz <= fp_sz[k];
      bus(1'b1, 4'h0, fp_ctl[k], 4'hf);
      @(posedge clk);
      @(negedge clk);
      cmp_word({30'h0, cfg.xfer}, {30'h0, fp_xf[k]});
      @(posedge clk);
    end
    // dram row hold without burst is flagged; long cas negation applies on dram
    bus(1'b1, 4'h0, 32'h8080_0000, 4'hf);
    @(posedge clk);
    @(negedge clk);
    cmp_word({28'h0, cfg.cas_cyc, cfg.burst, cfg.cfg_err}, {28'h0, 2'h2, 1'b0, 1'b1});
    @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire

// File: verilog/dtc_timing_config.sv
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_map.svh"

module dtc_timing_config (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // sequencer side
  input wire logic SDRAM_SEL,
  input wire logic MEM_AREA,
  input wire dtc_pkg::dtc_width_e AREA_WIDTH,
  input wire dtc_pkg::dtc_size_e XFER_SIZE,
  input wire dtc_pkg::dtc_event_s EVENTS,
  // timing permits
  output logic ACT_ALLOW,
  output logic PRE_ALLOW,
  output logic RAS_HOLD,
  // decoded configuration
  output dtc_pkg::dtc_cfg_s CFG
);

  dtc_pkg::dtc_state_s s_q;
  dtc_pkg::dtc_state_s s_d;

  // byte-enable merge of a bus write
  function automatic logic [31:0] dtc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // word decode, shared by read and write paths
  function automatic logic dtc_hit(input logic [3:0] addr, input logic [3:0] ofs);
    return addr[3:2] == ofs[3:2];
  endfunction

  function automatic logic [5:0] dtc_max(input logic [5:0] a, input logic [5:0] b);
    return (a > b) ? a : b;
  endfunction

  // address bits consumed by one beat of the given width
  function automatic logic [1:0] dtc_lane_shift(input dtc_pkg::dtc_width_e w);
    logic [1:0] r;
    r = 2'h2;
    unique case (w)
      dtc_pkg::W64: r = 2'h3;
      dtc_pkg::W32: r = 2'h2;
      dtc_pkg::W16: r = 2'h1;
      dtc_pkg::W_BAD: r = 2'h2;
    endcase
    return r;
  endfunction

  // whole next state; reset is synchronous so it is folded in here
  always_comb begin
    dtc_pkg::dtc_state_s b;
    dtc_pkg::dtc_event_s ev;
    logic [31:0] ctrl;
    logic [31:0] stat;
    logic req;
    logic sd;
    logic row_hold_mode;
    logic cas_negation_period;
    logic be;
    logic edo;
    logic ext;
    logic [2:0] refresh_precharge_wait;
    logic [2:0] row_precharge_period;
    logic [1:0] row_to_column_delay;
    logic [2:0] write_precharge_delay;
    logic [2:0] refresh_assert_period;
    logic [2:0] column_address_mux;
    logic [1:0] sz;
    logic [5:0] act_load;
    logic [5:0] act_dec;
    logic [2:0] pre_dec;
    logic page;
    // defaults first so no path leaves a latch behind
    ctrl = 32'h0000_0000;
    stat = 32'h0000_0000;
    sd = 1'b0;
    row_hold_mode = 1'b0;
    cas_negation_period = 1'b0;
    be = 1'b0;
    edo = 1'b0;
    ext = 1'b0;
    refresh_precharge_wait = 3'h0;
    row_precharge_period = 3'h0;
    row_to_column_delay = 2'h0;
    write_precharge_delay = 3'h0;
    refresh_assert_period = 3'h0;
    column_address_mux = 3'h0;
    sz = 2'h0;
    act_load = 6'h00;
    act_dec = 6'h00;
    pre_dec = 3'h0;
    page = 1'b0;
    b = s_q;
    ev = EVENTS;
    req = AVS_READ | AVS_WRITE;
    if (!RST_N) begin
      b = '0;
      b.bus = dtc_pkg::BUS_WAIT;
      b.ctrl = `DTC_CTRL_RST;
      ev = '0;
      req = 1'b0;
    end
    s_d = b;
    ctrl = b.ctrl;
    sd = SDRAM_SEL;

    // status word shows the live timing state
    stat = 32'h0000_0000;
    stat[`DTC_POS_ST_ACT_OK] = b.act_ok;
    stat[`DTC_POS_ST_PRE_OK] = b.pre_ok;
    stat[`DTC_POS_ST_RAS_HOLD] = b.ras_hold;
    stat[`DTC_POS_ST_CFG_ERR] = b.cfg.cfg_err;
    stat[`DTC_POS_ST_ACT_CNT +: 6] = b.act_cnt;
    stat[`DTC_POS_ST_PRE_CNT +: 3] = b.pre_cnt;
    stat[`DTC_POS_ST_RAS_CNT +: 4] = b.ras_cnt;

    // one wait cycle per access keeps every output a plain flop
    s_d.bus = dtc_pkg::BUS_WAIT;
    if (req && b.bus == dtc_pkg::BUS_WAIT) begin
      s_d.bus = dtc_pkg::BUS_ACK;
      if (dtc_hit(AVS_ADDRESS, `DTC_OFS_CTRL)) begin
        s_d.rdata = b.ctrl;
      end else if (dtc_hit(AVS_ADDRESS, `DTC_OFS_STAT)) begin
        s_d.rdata = stat;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    // write lands on the edge that sees waitrequest low
    if (AVS_WRITE && b.bus == dtc_pkg::BUS_ACK && dtc_hit(AVS_ADDRESS, `DTC_OFS_CTRL)) begin
      ctrl = dtc_merge(b.ctrl, AVS_WRITEDATA, AVS_BYTEENABLE) & `DTC_CTRL_WMASK;
    end
    s_d.ctrl = ctrl;

    // field extraction from the word in force next cycle
    row_hold_mode = ctrl[`DTC_POS_ROW_HOLD];
    refresh_precharge_wait = ctrl[`DTC_POS_REFRESH_WAIT +: 3];
    cas_negation_period = ctrl[`DTC_POS_CAS_NEG];
    row_precharge_period = ctrl[`DTC_POS_ROW_PRE +: 3];
    row_to_column_delay = ctrl[`DTC_POS_ROW_COL +: 2];
    write_precharge_delay = ctrl[`DTC_POS_WR_PRE +: 3];
    refresh_assert_period = ctrl[`DTC_POS_REF_ASSERT +: 3];
    be = ctrl[`DTC_POS_BURST];
    sz = ctrl[`DTC_POS_WIDTH +: 2];
    ext = ctrl[`DTC_POS_MUX_EXT];
    column_address_mux = ctrl[`DTC_POS_COL_MUX +: 3];
    edo = ctrl[`DTC_POS_EXT_OUT];

    // dram refresh: ras held for code plus two cycles
    s_d.ras_cnt = (b.ras_cnt == 4'h0) ? 4'h0 : b.ras_cnt - 4'h1;
    if (ev.refresh && !sd) begin
      s_d.ras_cnt = 4'(refresh_assert_period) + `DTC_REF_ASSERT_BASE;
    end
    s_d.ras_hold = s_d.ras_cnt != 4'h0;

    // active lockout: worst case of every pending cause wins
    act_load = 6'h00;
    if (ev.precharge) begin
      act_load = sd ? 6'(row_precharge_period) + 6'h01 : 6'(row_precharge_period);
    end
    if (ev.write_end && sd && !row_hold_mode) begin
      act_load = dtc_max(act_load, 6'(row_precharge_period) + 6'h01 + 6'(write_precharge_delay) + 6'h01);
    end
    if (ev.refresh && sd) begin
      act_load = dtc_max(act_load, 6'(refresh_precharge_wait) * `DTC_REFRESH_WAIT_STEP + 6'(refresh_assert_period)
                                   + `DTC_SD_REFRESH_BASE);
    end
    // dram refresh ends when ras drops; precharge wait runs from there
    if (!sd && b.ras_cnt == 4'h1) begin
      act_load = dtc_max(act_load, dtc_max(6'(refresh_precharge_wait) * `DTC_REFRESH_WAIT_STEP, 6'(row_precharge_period)));
    end
    act_dec = (b.act_cnt == 6'h00) ? 6'h00 : b.act_cnt - 6'h01;
    s_d.act_cnt = dtc_max(act_dec, act_load);
    s_d.act_ok = (s_d.act_cnt == 6'h00) && !s_d.ras_hold;

    // row hold mode: write to next precharge gap
    pre_dec = (b.pre_cnt == 3'h0) ? 3'h0 : b.pre_cnt - 3'h1;
    s_d.pre_cnt = pre_dec;
    if (ev.write_end && sd && row_hold_mode) begin
      s_d.pre_cnt = 3'(write_precharge_delay) + 3'h1;
    end
    s_d.pre_ok = s_d.pre_cnt == 3'h0;

    // cas negation only matters on the dram interface
    s_d.cfg.cas_cyc = (!sd && cas_negation_period) ? 2'h2 : 2'h1;

    // row to column delay; banned sdram code clamps to the shortest
    if (sd) begin
      s_d.cfg.rc_cyc = (row_to_column_delay == 2'b00) ? `DTC_ROW_COL_BASE : 3'(row_to_column_delay) + 3'h1;
    end else begin
      s_d.cfg.rc_cyc = 3'(row_to_column_delay) + `DTC_ROW_COL_BASE;
    end

    // memory areas take the control word width, others the area width
    s_d.cfg.width = MEM_AREA ? dtc_pkg::dtc_width_e'(sz) : AREA_WIDTH;

    // column bits and row shift; sdram adds extension and a bank bit
    s_d.cfg.col_bits = `DTC_COL_BITS_BASE + 4'(column_address_mux) + ((sd && ext) ? 4'h1 : 4'h0);
    s_d.cfg.row_shift = 5'(s_d.cfg.col_bits) + 5'(dtc_lane_shift(dtc_pkg::dtc_width_e'(sz)))
                        + (sd ? 5'h01 : 5'h00);

    // transfer mode selection
    page = (XFER_SIZE == dtc_pkg::S32B)
           || (sz == 2'b10 && (XFER_SIZE == dtc_pkg::S32 || XFER_SIZE == dtc_pkg::S64))
           || (sz == 2'b11 && XFER_SIZE == dtc_pkg::S64);
    s_d.cfg.burst = sd | be;
    if (sd) begin
      s_d.cfg.xfer = dtc_pkg::XF_SD_BURST;
    end else if (!be) begin
      s_d.cfg.xfer = dtc_pkg::XF_SINGLE;
    end else if (edo) begin
      s_d.cfg.xfer = dtc_pkg::XF_EDO;
    end else begin
      s_d.cfg.xfer = page ? dtc_pkg::XF_PAGE : dtc_pkg::XF_SINGLE;
    end

    // flag banned settings; hardware runs on the raw codes, except sdram row to column code 00, which clamps
    s_d.cfg.cfg_err = (sd && write_precharge_delay > 3'h4)
                      || (sz == 2'b01) || (sd && sz == 2'b10)
                      || (!sd && !be && edo)
                      || (!sd && (column_address_mux > 3'h4 || ext))
                      || (sd && row_to_column_delay == 2'b00)
                      || (sd && row_hold_mode && (row_precharge_period == 3'h0 || row_precharge_period >= 3'h3
                          || row_to_column_delay == 2'b11 || write_precharge_delay >= 3'h2))
                      || (!sd && row_hold_mode && !be);
  end

  // single state register, synchronous reset handled above
  always_ff @(posedge REF_CLK) begin
    s_q <= s_d;
  end

  // all outputs straight from the state register
  assign AVS_READDATA = s_q.rdata;
  assign AVS_WAITREQUEST = s_q.bus;
  assign ACT_ALLOW = s_q.act_ok;
  assign PRE_ALLOW = s_q.pre_ok;
  assign RAS_HOLD = s_q.ras_hold;
  assign CFG = s_q.cfg;

endmodule
`default_nettype wire
